// *** adc_four_wire_readout_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_four_wire_readout_test
    import afr_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_q = 1'b0;
    logic early_q = 1'b0;
    logic busy_q = 1'b0;
    logic stat_q = 1'b0;
    logic [AFR_DATA_BITS-1:0] sample_q = 18'h0;
    logic host_busy;
    logic host_done;
    logic pwr1;
    logic conv2;
    logic [AFR_FRAME_BITS-1:0] host_data;
    int err_count = 0;
    int n_tests = 0;
    int k;
    always #50 clk_sys_in = ~clk_sys_in;

    afr_link_if i_afr_link_if();
    // Second link: bench stands in for the host to probe the wire
    afr_link_if i_afr_link_if_2();
    afr_device i_afr_device (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .link(i_afr_link_if.device), .early_en_in(early_q), .stat_en_in(stat_q),
        .sample_in(sample_q), .converting_out(), .powered_out(pwr1));
    afr_device i_afr_device_2 (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .link(i_afr_link_if_2.device), .early_en_in(early_q), .stat_en_in(stat_q),
        .sample_in(sample_q), .converting_out(conv2), .powered_out());
    afr_host i_afr_host (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .link(i_afr_link_if.host), .start_in(start_q), .early_en_in(early_q),
        .busy_mode_in(busy_q), .stat_en_in(stat_q), .busy_out(host_busy),
        .done_out(host_done), .data_out(host_data));
    afr_link_properties i_afr_link_properties (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .convert_start_input(i_afr_link_if.convert_start_input),
        .sdi(i_afr_link_if.sdi), .sck(i_afr_link_if.sck), .sdo_o(i_afr_link_if.sdo_o),
        .sdo_oe(i_afr_link_if.sdo_oe), .sdo(i_afr_link_if.sdo));

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : tick

    task automatic host_run(input logic e, input logic b, input logic s,
        input logic [17:0] smp, input logic [23:0] exp);
        int i;
        early_q <= e;
        busy_q <= b;
        stat_q <= s;
        sample_q <= smp;
        tick(1);
        start_q <= 1'b1;
        for (i = 0; i < 20 && host_busy !== 1'b1; i++) tick(1);
        if (i == 20)
        begin
            err_count++;
            $display("[ERR] busy_out expected 1 seen timeout");
            report_and_stop();
        end
        start_q <= 1'b0;
        for (i = 0; i < 2000 && host_done !== 1'b1; i++) tick(1);
        if (i == 2000)
        begin
            err_count++;
            $display("[ERR] done_out expected 1 seen timeout");
            report_and_stop();
        end
        check("data_out", host_data, exp);
        check("powered_out", 24'(pwr1), 24'h0);
        $display("test e=%0b b=%0b s=%0b ended", e, b, s);
    endtask : host_run

    initial
    begin
        i_afr_link_if_2.convert_start_input = 1'b0;
        i_afr_link_if_2.sdi = 1'b1;
        i_afr_link_if_2.sck = 1'b0;
        tick(6);
        rst_in <= 1'b0;
        host_run(0, 0, 0, 18'h2a5c3, {18'h2a5c3, 6'h00});
        host_run(0, 0, 1, 18'h15a3c, {18'h15a3c, 6'h00});
        host_run(0, 1, 1, 18'h3f00f, {18'h3f00f, 6'h00});
        host_run(0, 1, 0, 18'h00001, {18'h00001, 6'h00});
        rst_in <= 1'b1;
        tick(6);
        rst_in <= 1'b0;
        tick(1);
        check("data_out reset", host_data, 24'h0);
        host_run(1, 0, 1, 18'h1234a, {18'h00000, 6'h04});
        host_run(1, 0, 1, 18'h2bcde, {18'h1234a, 6'h04});
        host_run(1, 1, 0, 18'h0f0f0, {18'h2bcde, 6'h00});
        early_q <= 1'b0;
        stat_q <= 1'b0;
        tick(1);
        i_afr_link_if_2.convert_start_input <= 1'b1;
        tick(5);
        i_afr_link_if_2.sdi <= 1'b0;
        tick(6);
        check("sdo_oe early select", 24'(i_afr_link_if_2.sdo_oe), 24'h0);
        check("converting_out", 24'(conv2), 24'h1);
        i_afr_link_if_2.sdi <= 1'b1;
        tick(40);
        check("converting_out end", 24'(conv2), 24'h0);
        i_afr_link_if_2.sdi <= 1'b0;
        tick(6);
        check("sdo msb", 24'(i_afr_link_if_2.sdo), 24'(sample_q[17]));
        for (k = 0; k < 18; k++)
        begin
            i_afr_link_if_2.sck <= 1'b1;
            tick(2);
            check("sdo bit", 24'(i_afr_link_if_2.sdo), 24'(sample_q[17-k]));
            tick(2);
            i_afr_link_if_2.sck <= 1'b0;
            tick(4);
        end
        tick(2);
        check("sdo_oe after frame", 24'(i_afr_link_if_2.sdo_oe), 24'h0);
        i_afr_link_if_2.sdi <= 1'b1;
        i_afr_link_if_2.convert_start_input <= 1'b0;
        $display("test wire read ended");
        report_and_stop();
    end
endmodule : adc_four_wire_readout_test
`default_nettype wire

// *** afr_device.sv ***
// Operation
// [R1] Early-readout bit set selects early readout
// [R2] Early readout replaces busy-indicator mode
// [R3] Early readout shifts previous conversion result
// [R4] Early readout off after reset; host clears
// [R5] Convert rise starts conversion, SDO released
// [R6] Host holds convert high through readback
// [R7] Host holds SDI high at convert rise
// [R8] Host waits first quiet interval first
// [R9] After conversion time, power down converter
// [R10] SDI fall drives MSB without clock
// [R11] Result MSB first on first 18 falls
// [R12] Status bits on falls 19 to 24
// [R13] Early readout: release on end or convert
// [R14] Host leaves second quiet interval
// [R15] No-busy: SDI high through conversion time
// [R16] Host keeps SCK idle during conversion; in early readout the host clocks SCK from the end of the first quiet interval
// [R17] No-busy: release on end or SDI rise
// [R18] One SDI low at a time
// [R19] Busy: SDI low through conversion time
// [R20] Busy: drive SDO low at conversion end
// [R21] Busy: release after extra fall or convert
// [R22] Status bit 2 shows early-readout enable
`timescale 1ns/1ps
`default_nettype none
module afr_device
    import afr_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    afr_link_if.device link,
    input wire logic early_en_in,
    input wire logic stat_en_in,
    input wire logic [AFR_DATA_BITS-1:0] sample_in,
    output logic converting_out,
    output logic powered_out
);
    logic cnv_s;
    logic sdi_s;
    logic sck_s;
    logic cnv_q;
    logic sdi_q;
    logic sck_q;
    logic early_q;
    logic stat_q;
    logic conv_q;
    logic [AFR_TMR_W-1:0] tmr_q;
    logic [AFR_DATA_BITS-1:0] res_q;
    logic [AFR_DATA_BITS-1:0] prev_q;
    logic [AFR_FRAME_BITS-1:0] sh_q;
    logic [AFR_CNT_W-1:0] cnt_q;
    logic drive_q;
    logic sdo_q;
    logic irq_wait_q;
    logic powered_q;
    logic rd_busy_q;

    afr_sync u_cnv
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .async_in(link.convert_start_input),
        .sync_out(cnv_s)
    );
    afr_sync u_sdi
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .async_in(link.sdi),
        .sync_out(sdi_s)
    );
    afr_sync u_sck
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .async_in(link.sck),
        .sync_out(sck_s)
    );

    wire cnv_rise = cnv_s & ~cnv_q;
    wire sdi_fall = ~sdi_s & sdi_q;
    wire sdi_rise = sdi_s & ~sdi_q;
    wire sck_fall = ~sck_s & sck_q;
    wire conv_done = conv_q && (tmr_q == AFR_TMR_W'(AFR_CONV_CYC - 1));
    // Busy mode unreachable while early readout is on [R2]
    wire busy_mode = ~early_q;
    wire [AFR_DATA_BITS-1:0] word_sel = early_q ? prev_q : res_q; // [R3]
    wire [AFR_STAT_BITS-1:0] status_w =
        {AFR_ST_UPPER, early_q, AFR_ST_RSVD}; // [R22]
    wire [AFR_FRAME_BITS-1:0] frame_w = {word_sel, status_w};
    wire [AFR_CNT_W-1:0] frame_len = afr_frame_len(stat_q);
    wire last_fall = drive_q && sck_fall && (cnt_q == frame_len - AFR_CNT_W'(1));
    wire extra_fall = drive_q && sck_fall && (cnt_q == frame_len);
    // Busy read holds the line through the data; the extra fall releases it
    wire rel_fall = rd_busy_q ? extra_fall : last_fall;
    // Read starts on SDI fall: in early mode also during a conversion, in no-busy mode only outside one
    wire cs_start = sdi_fall && (early_q || !conv_q) && !irq_wait_q;
    // Interrupt flag only when the host already holds SDI low at the end
    wire irq_start = conv_done && busy_mode && !sdi_s;
    wire desel = sdi_rise && drive_q && !conv_q && !early_q && !irq_wait_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            cnv_q <= 1'b0;
            // Same level as the synchroniser, so no false select after reset
            sdi_q <= 1'b0;
            sck_q <= 1'b0;
            early_q <= 1'b0; // [R4]
            stat_q <= 1'b0;
            conv_q <= 1'b0;
            tmr_q <= '0;
            res_q <= '0;
            prev_q <= '0;
            sh_q <= '0;
            cnt_q <= '0;
            drive_q <= 1'b0;
            sdo_q <= 1'b0;
            irq_wait_q <= 1'b0;
            powered_q <= 1'b0;
            rd_busy_q <= 1'b0;
        end
        else
        begin
            cnv_q <= cnv_s;
            sdi_q <= sdi_s;
            sck_q <= sck_s;
            if (cnv_rise)
            begin
                // Config latched per conversion so a frame never changes shape
                early_q <= early_en_in; // [R1]
                stat_q <= stat_en_in;
                conv_q <= 1'b1; // [R5]
                powered_q <= 1'b1;
                tmr_q <= '0;
                drive_q <= 1'b0; // [R5] [R13] [R21]
                irq_wait_q <= 1'b0;
                rd_busy_q <= 1'b0;
                prev_q <= res_q; // [R3]
            end
            else
            begin
                if (conv_q)
                begin
                    tmr_q <= tmr_q + AFR_TMR_W'(1);
                end
                // Kept apart from the read logic: an early read may see an SCK
                // fall in the very cycle the conversion ends
                if (conv_done)
                begin
                    conv_q <= 1'b0;
                    powered_q <= 1'b0; // [R9]
                    res_q <= sample_in;
                end
                if (irq_start)
                begin
                    // End-of-conversion interrupt, then MSB on next fall
                    drive_q <= 1'b1; // [R20]
                    sdo_q <= 1'b0;
                    irq_wait_q <= 1'b1;
                    rd_busy_q <= 1'b1;
                    sh_q <= {sample_in, status_w};
                    cnt_q <= '0;
                end
                else if (cs_start)
                begin
                    drive_q <= 1'b1;
                    rd_busy_q <= 1'b0;
                    sh_q <= frame_w << 1;
                    sdo_q <= frame_w[AFR_FRAME_BITS-1]; // [R10]
                    cnt_q <= '0;
                end
                else if (irq_wait_q && sck_fall)
                begin
                    // This fall brings the MSB and counts as the first one
                    irq_wait_q <= 1'b0;
                    sdo_q <= sh_q[AFR_FRAME_BITS-1]; // [R20]
                    sh_q <= sh_q << 1;
                    cnt_q <= AFR_CNT_W'(1);
                end
                else if (desel)
                begin
                    drive_q <= 1'b0; // [R17]
                end
                else if (!irq_wait_q && drive_q && sck_fall)
                begin
                    cnt_q <= cnt_q + AFR_CNT_W'(1);
                    sdo_q <= sh_q[AFR_FRAME_BITS-1]; // [R11] [R12]
                    sh_q <= sh_q << 1;
                    if (rel_fall)
                    begin
                        drive_q <= 1'b0; // [R13] [R17] [R21]
                    end
                end
            end
        end
    end

    assign link.sdo_o = sdo_q;
    assign link.sdo_oe = drive_q;
    assign converting_out = conv_q;
    assign powered_out = powered_q;
endmodule : afr_device
`default_nettype wire

// *** afr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module afr_host
    import afr_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    afr_link_if.host link,
    input wire logic start_in,
    input wire logic early_en_in,
    input wire logic busy_mode_in,
    input wire logic stat_en_in,
    output logic busy_out,
    output logic done_out,
    output logic [AFR_FRAME_BITS-1:0] data_out
);
    typedef enum logic [5:0]
    {
        ST_IDLE = 6'h01,
        ST_CONV = 6'h02,
        ST_WAITIRQ = 6'h04,
        ST_SHIFT = 6'h08,
        ST_QUIET = 6'h10,
        ST_END = 6'h20
    } afr_hst_t;

    afr_hst_t st_q;
    logic cnv_q;
    logic sdi_q;
    logic sck_q;
    logic [AFR_TMR_W-1:0] tmr_q;
    logic [AFR_CNT_W-1:0] cnt_q;
    logic [AFR_FRAME_BITS-1:0] sh_q;
    logic [AFR_FRAME_BITS-1:0] data_q;
    logic done_q;
    logic early_q;
    logic busy_q;
    logic stat_q;
    logic sdo_s;

    afr_sync u_sdo (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .async_in(link.sdo), .sync_out(sdo_s));

    wire [AFR_CNT_W-1:0] nbits = afr_frame_len(stat_q);
    wire half_done = tmr_q == AFR_TMR_W'(AFR_SCK_HALF - 1);
    wire conv_over = tmr_q == AFR_TMR_W'(AFR_CONV_CYC + 4);
    wire quiet1_ok = tmr_q >= AFR_TMR_W'(AFR_QUIET1_CYC + 2);

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            st_q <= ST_IDLE;
            cnv_q <= 1'b0;
            sdi_q <= 1'b1;
            sck_q <= 1'b0;
            tmr_q <= '0;
            cnt_q <= '0;
            sh_q <= '0;
            data_q <= '0;
            done_q <= 1'b0;
            early_q <= 1'b0;
            busy_q <= 1'b0;
            stat_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            tmr_q <= tmr_q + AFR_TMR_W'(1);
            unique case (st_q)
                ST_IDLE:
                    if (start_in)
                    begin
                        cnv_q <= 1'b1; // [R6]
                        sdi_q <= 1'b1; // [R7]
                        early_q <= early_en_in;
                        busy_q <= busy_mode_in & ~early_en_in; // [R2]
                        stat_q <= stat_en_in;
                        tmr_q <= '0;
                        st_q <= ST_CONV;
                    end
                ST_CONV:
                    if (early_q && quiet1_ok)
                    begin
                        sdi_q <= 1'b0; // [R8]
                        tmr_q <= '0;
                        cnt_q <= '0;
                        st_q <= ST_SHIFT;
                    end
                    // Lowered once the device has seen SDI high at the convert
                    // rise, still well before the conversion can end
                    else if (!early_q && busy_q && tmr_q == AFR_TMR_W'(AFR_QUIET1_CYC + 2))
                        sdi_q <= 1'b0; // [R19]
                    else if (!early_q && conv_over)
                    begin
                        // SDI stays high in no-busy mode until here [R15] [R18]
                        tmr_q <= '0;
                        cnt_q <= '0;
                        sdi_q <= 1'b0;
                        st_q <= busy_q ? ST_WAITIRQ : ST_SHIFT;
                    end
                ST_WAITIRQ:
                    if (!sdo_s && half_done)
                    begin
                        // Extra fall moves the MSB out after the low flag
                        sck_q <= ~sck_q;
                        tmr_q <= '0;
                        if (sck_q)
                            st_q <= ST_SHIFT;
                    end
                    else if (half_done)
                        tmr_q <= '0;
                ST_SHIFT:
                    if (half_done)
                    begin
                        tmr_q <= '0;
                        sck_q <= ~sck_q; // [R16]
                        // Sampled just before each fall: the synchronised line
                        // lags, and the bit stands until the fall moves it on
                        if (sck_q)
                        begin
                            sh_q <= {sh_q[AFR_FRAME_BITS-2:0], sdo_s};
                            cnt_q <= cnt_q + AFR_CNT_W'(1);
                            if (cnt_q == nbits - AFR_CNT_W'(1))
                                st_q <= ST_QUIET;
                        end
                    end
                ST_QUIET:
                    if (tmr_q >= AFR_TMR_W'(AFR_QUIET2_CYC)) // [R14]
                    begin
                        sdi_q <= 1'b1;
                        cnv_q <= 1'b0;
                        st_q <= ST_END;
                    end
                ST_END:
                begin
                    data_q <= stat_q ? sh_q : {sh_q[AFR_DATA_BITS-1:0],
                        AFR_STAT_BITS'(0)};
                    done_q <= 1'b1;
                    st_q <= ST_IDLE;
                end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    assign link.convert_start_input = cnv_q;
    assign link.sdi = sdi_q;
    assign link.sck = sck_q;
    assign busy_out = ~st_q[0];
    assign done_out = done_q;
    assign data_out = data_q;
endmodule : afr_host
`default_nettype wire

// *** afr_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface afr_link_if;
    logic convert_start_input;
    logic sdi;
    logic sck;
    logic sdo_o;
    logic sdo_oe;
    // Pull-up on the shared result line
    wire sdo = sdo_oe ? sdo_o : 1'b1;

    modport device
    (
        input convert_start_input,
        input sdi,
        input sck,
        output sdo_o,
        output sdo_oe
    );

    modport host
    (
        output convert_start_input,
        output sdi,
        output sck,
        input sdo
    );
endinterface : afr_link_if
`default_nettype wire

// *** afr_link_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module afr_link_properties
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic convert_start_input,
    input wire logic sdi,
    input wire logic sck,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic sdo
);
    logic sck_q;
    logic [4:0] fall_cnt_q;
    logic [4:0] fall_cnt_d;
    wire logic sck_fall = sck_q && !sck;
    // Falls counted only while driven, so each frame starts from zero
    assign fall_cnt_d = sdo_oe ? fall_cnt_q + 5'(sck_fall) : 5'h0;
    always_ff @(posedge clk_sys_in)
    begin
        sck_q <= rst_in ? 1'b0 : sck;
        fall_cnt_q <= rst_in ? 5'h0 : fall_cnt_d;
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    sequence s_start;
        $rose(convert_start_input) && sdi;
    endsequence
    sequence s_quiet;
        sdi [*3];
    endsequence

    a_start_sdi_high: assert property ($rose(convert_start_input) |-> sdi)
        else $error("sdi low at convert rise");
    a_quiet_one_wait: assert property (s_start |-> s_quiet)
        else $error("sdi fell inside first quiet interval");
    a_start_release: assert property (s_start |-> ##5 !sdo_oe)
        else $error("sdo still driven after convert rise");
    a_sck_idle_start: assert property (s_start |-> !sck [*4])
        else $error("sck active at conversion start");
    a_quiet_two_wait: assert property (sck_fall |-> !$rose(convert_start_input) [*3])
        else $error("convert rose inside second quiet interval");
    a_desel_release: assert property (sdi [*5] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    a_select_answer: assert property ($fell(sdi) |-> ##[1:40] sdo_oe)
        else $error("no answer on sdo after select");
    a_irq_low: assert property ($rose(sdo_oe) && !$past(sdi, 8) |-> !sdo)
        else $error("end of conversion not signalled low");
    a_bit_hold: assert property ($rose(sck) && sdo_oe && $past(sdo_oe, 4)
        |=> $stable(sdo_o) [*3])
        else $error("sdo bit changed during sck high");
    a_frame_min: assert property ($fell(sdo_oe) |-> fall_cnt_q >= 5'd18)
        else $error("sdo released before full result");
    a_frame_max: assert property (fall_cnt_q <= 5'd25)
        else $error("sdo driven beyond frame");
endmodule : afr_link_properties
`default_nettype wire

// *** afr_pkg.sv ***
package afr_pkg;
    localparam int unsigned AFR_CLK_HZ = 10_000_000;
    localparam int unsigned AFR_DATA_BITS = 18;
    localparam int unsigned AFR_STAT_BITS = 6;
    localparam int unsigned AFR_FRAME_BITS = AFR_DATA_BITS + AFR_STAT_BITS;
    localparam int unsigned AFR_CNT_W = 5;
    // Conversion_time and quiet intervals in ns
    localparam int unsigned AFR_CONV_NS = 3000;
    localparam int unsigned AFR_QUIET1_NS = 300;
    localparam int unsigned AFR_QUIET2_NS = 300;
    localparam int unsigned AFR_CONV_CYC = (AFR_CONV_NS * (AFR_CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned AFR_QUIET1_CYC =
        (AFR_QUIET1_NS * (AFR_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned AFR_QUIET2_CYC =
        (AFR_QUIET2_NS * (AFR_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned AFR_TMR_W = 8;
    // Host SCK half period in system clocks (link divider)
    localparam int unsigned AFR_SCK_HALF = 4;
    // Status word layout
    localparam int unsigned AFR_ST_EARLY_BIT = 2;
    localparam logic [1:0] AFR_ST_RSVD = 2'h0;
    localparam logic [2:0] AFR_ST_UPPER = 3'h0;

    typedef enum logic [1:0]
    {
        AFR_MODE_NOBUSY = 2'h0,
        AFR_MODE_BUSY = 2'h1
    } afr_mode_t;

    function automatic logic [AFR_CNT_W-1:0] afr_frame_len(input logic stat_en);
        afr_frame_len = stat_en ? AFR_CNT_W'(AFR_FRAME_BITS) : AFR_CNT_W'(AFR_DATA_BITS);
    endfunction : afr_frame_len
endpackage : afr_pkg

// *** afr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module afr_sync
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : afr_sync
`default_nettype wire
